// File: core/scg_regs.svh
`ifndef SCG_REGS_SVH
`define SCG_REGS_SVH

// coefficient and data word width, and width of the wide intermediate
`define SCG_WORD_W 24
`define SCG_PROD_W 50
// reset value of the coefficient register
`define SCG_COEFF_RST 24'h000000
// fraction bits of the coefficient: 0x400000 is unity gain
`define SCG_FRAC_BITS 22
// rounding constant, half an lsb of the scaled result
`define SCG_ROUND_BIT 21
// last bit index of a serial access
`define SCG_LAST_BIT 5'h17
// saturation limits of a 24-bit signed word
`define SCG_POS_MAX 24'h7fffff
`define SCG_NEG_MAX 24'h800000

`endif

// File: core/scg_pkg.sv
`include "scg_regs.svh"

package scg_pkg;
    // signed data and coefficient word
    typedef logic signed [`SCG_WORD_W-1:0] scg_word_t;
    // wide intermediate for differences and products
    typedef logic signed [`SCG_PROD_W-1:0] scg_wide_t;

    // serial access states, one-hot
    typedef enum logic [2:0] {
        SCG_IDLE = 3'h1,
        SCG_WR = 3'h2,
        SCG_RD = 3'h4
    } scg_state_t;

    // clamp a wide signed value into a data word
    function automatic scg_word_t scg_sat(input scg_wide_t v);
        scg_wide_t hi;
        scg_wide_t lo;
        hi = scg_wide_t'(signed'(`SCG_POS_MAX));
        lo = scg_wide_t'(signed'(`SCG_NEG_MAX));
        if (v > hi) begin
            return `SCG_POS_MAX;
        end else if (v < lo) begin
            return `SCG_NEG_MAX;
        end
        return v[`SCG_WORD_W-1:0];
    endfunction
endpackage

// File: core/scg_mul_if.sv
`timescale 1ns/1ps

// carries offset-corrected samples into the gain stage and back
interface scg_mul_if;
    logic in_valid;
    scg_pkg::scg_word_t in_data;
    scg_pkg::scg_word_t coeff;
    logic bypass;
    logic out_valid;
    scg_pkg::scg_word_t out_data;

    modport src (output in_valid, output in_data, output coeff, output bypass,
                 input out_valid, input out_data);
    modport stage (input in_valid, input in_data, input coeff, input bypass,
                   output out_valid, output out_data);
endinterface

// File: core/scg_gain_stage.sv
`timescale 1ns/1ps
`include "scg_regs.svh"

module scg_gain_stage (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // sample path
    scg_mul_if.stage mif
);
    import scg_pkg::*;

    scg_wide_t prod;
    scg_wide_t scaled;
    logic out_valid_ff;
    scg_word_t out_data_ff;

    // signed q2.22 product, rounded to nearest so error stays under an lsb
    always_comb begin
        prod = scg_wide_t'(mif.in_data) * scg_wide_t'(mif.coeff);
        scaled = (prod + (scg_wide_t'(1) <<< `SCG_ROUND_BIT)) >>> `SCG_FRAC_BITS;
    end

    // one register stage; bypass passes the sample untouched
    always_ff @(posedge mclk) begin
        if (reset) begin
            out_valid_ff <= 1'b0;
            out_data_ff <= `SCG_COEFF_RST;
        end else begin
            out_valid_ff <= mif.in_valid;
            if (mif.in_valid) begin
                out_data_ff <= mif.bypass ? mif.in_data : scg_sat(scaled);
            end
        end
    end

    assign mif.out_valid = out_valid_ff;
    assign mif.out_data = out_data_ff;
endmodule

// File: core/scg_top.sv
`timescale 1ns/1ps
`include "scg_regs.svh"

module scg_top (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // serial register access, framed by the interface logic upstream
    input wire logic acc_start,
    input wire logic acc_write,
    input wire logic bit_stb,
    input wire logic sdi,
    output logic sdo,
    output logic acc_done,
    output logic wr_dropped,
    // calibration sequencer
    input wire logic cal_busy,
    input wire logic cal_done,
    input wire scg_pkg::scg_word_t cal_result,
    // control bits and offset coefficient
    input wire logic self_gain_bypass,
    input wire logic self_offset_bypass,
    input wire scg_pkg::scg_word_t self_cal_offset_coeff,
    // conversion path
    input wire logic raw_valid,
    input wire scg_pkg::scg_word_t raw_result,
    output logic res_valid,
    output scg_pkg::scg_word_t res_data,
    // coefficient readout
    output scg_pkg::scg_word_t coeff_value
);
    import scg_pkg::*;

    scg_state_t state_ff;
    scg_state_t nxt_state;
    logic [4:0] bit_cnt_ff;
    logic [`SCG_WORD_W-1:0] shift_ff;
    scg_word_t self_cal_gain_coeff_ff;
    logic busy_seen_ff;
    logic done_ff;
    logic dropped_ff;
    logic sdo_ff;
    logic last_bit;
    logic commit;
    logic off_valid_ff;
    scg_word_t off_data_ff;
    logic res_valid_ff;
    scg_word_t res_data_ff;
    scg_wide_t diff;

    scg_mul_if mif();

    // msb-first shift of one serial bit into a word, shared by shifter and commit
    function automatic logic [`SCG_WORD_W-1:0] scg_shift_in(input logic [`SCG_WORD_W-1:0] w,
            input logic b);
        return {w[`SCG_WORD_W-2:0], b};
    endfunction

    // last strobe of a 24-bit access
    assign last_bit = bit_stb && (bit_cnt_ff == `SCG_LAST_BIT);

    // write lands only if no calibration was seen during the access
    // cal_busy is checked live too: busy_seen_ff cannot yet hold the last strobe edge
    assign commit = state_ff[1] && last_bit && !busy_seen_ff && !cal_busy;

    // access sequencing
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SCG_IDLE: begin
                if (acc_start) begin
                    nxt_state = acc_write ? SCG_WR : SCG_RD;
                end
            end
            SCG_WR: begin
                if (last_bit) begin
                    nxt_state = SCG_IDLE;
                end
            end
            SCG_RD: begin
                if (last_bit) begin
                    nxt_state = SCG_IDLE;
                end
            end
            default: begin
                nxt_state = SCG_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_ff <= SCG_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // bit counter, restarts with every access
    always_ff @(posedge mclk) begin
        if (reset) begin
            bit_cnt_ff <= 5'h00;
        end else if (state_ff[0]) begin
            bit_cnt_ff <= 5'h00;
        end else if (bit_stb) begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end
    end

    // shifter: loads coefficient for reads, msb leaves and enters first
    always_ff @(posedge mclk) begin
        if (reset) begin
            shift_ff <= `SCG_COEFF_RST;
        end else if (state_ff[0] && acc_start) begin
            shift_ff <= acc_write ? `SCG_COEFF_RST : self_cal_gain_coeff_ff;
        end else if (!state_ff[0] && bit_stb) begin
            shift_ff <= scg_shift_in(shift_ff, sdi);
        end
    end

    // a calibration anywhere inside a write voids it, not only at the end
    always_ff @(posedge mclk) begin
        if (reset) begin
            busy_seen_ff <= 1'b0;
        end else if (state_ff[0]) begin
            busy_seen_ff <= acc_start && cal_busy;
        end else if (cal_busy) begin
            busy_seen_ff <= 1'b1;
        end
    end

    // coefficient register; calibration result outranks a host write
    always_ff @(posedge mclk) begin
        if (reset) begin
            self_cal_gain_coeff_ff <= `SCG_COEFF_RST;
        end else if (cal_done) begin
            self_cal_gain_coeff_ff <= cal_result;
        end else if (commit) begin
            self_cal_gain_coeff_ff <= scg_shift_in(shift_ff, sdi);
        end
    end

    // access status pulses
    always_ff @(posedge mclk) begin
        if (reset) begin
            done_ff <= 1'b0;
            dropped_ff <= 1'b0;
        end else begin
            done_ff <= !state_ff[0] && last_bit;
            dropped_ff <= state_ff[1] && last_bit && !commit;
        end
    end

    // read data from a flop, kept one bit ahead so it matches the shifter msb
    always_ff @(posedge mclk) begin
        if (reset) begin
            sdo_ff <= 1'b0;
        end else if (state_ff[0]) begin
            sdo_ff <= acc_start && !acc_write && self_cal_gain_coeff_ff[`SCG_WORD_W-1];
        end else if (state_ff[2] && bit_stb) begin
            sdo_ff <= !last_bit && shift_ff[`SCG_WORD_W-2];
        end else if (!state_ff[2]) begin
            sdo_ff <= 1'b0;
        end
    end

    // status pulses and readout come straight from flops
    assign acc_done = done_ff;
    assign wr_dropped = dropped_ff;
    // read data stands on sdo from the access start, msb first
    assign sdo = sdo_ff;
    assign coeff_value = self_cal_gain_coeff_ff;

    // offset stage ahead of the gain stage
    always_comb begin
        diff = scg_wide_t'(raw_result);
        if (!self_offset_bypass) begin
            diff = scg_wide_t'(raw_result) - scg_wide_t'(self_cal_offset_coeff);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            off_valid_ff <= 1'b0;
            off_data_ff <= `SCG_COEFF_RST;
        end else begin
            off_valid_ff <= raw_valid;
            if (raw_valid) begin
                off_data_ff <= scg_sat(diff);
            end
        end
    end

    // gain stage sees the live coefficient; system corrections follow later
    assign mif.in_valid = off_valid_ff;
    assign mif.in_data = off_data_ff;
    assign mif.coeff = self_cal_gain_coeff_ff;
    assign mif.bypass = self_gain_bypass;

    scg_gain_stage u_gain (
        .mclk(mclk),
        .reset(reset),
        .mif(mif)
    );

    // output register handed to the system offset stage
    always_ff @(posedge mclk) begin
        if (reset) begin
            res_valid_ff <= 1'b0;
            res_data_ff <= `SCG_COEFF_RST;
        end else begin
            res_valid_ff <= mif.out_valid;
            if (mif.out_valid) begin
                res_data_ff <= mif.out_data;
            end
        end
    end

    assign res_valid = res_valid_ff;
    assign res_data = res_data_ff;
endmodule

// File: tb/scg_props.sv
`timescale 1ns/1ps
// pin-level checks of the coefficient register and the sample path
module scg_props (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // access and calibration
    input wire logic bit_stb,
    input wire logic sdo,
    input wire logic acc_done,
    input wire logic wr_dropped,
    input wire logic cal_done,
    input wire scg_pkg::scg_word_t cal_result,
    // sample path
    input wire logic self_gain_bypass,
    input wire logic self_offset_bypass,
    input wire logic raw_valid,
    input wire scg_pkg::scg_word_t raw_result,
    input wire logic res_valid,
    input wire scg_pkg::scg_word_t res_data,
    input wire scg_pkg::scg_word_t coeff_value
);
    import scg_pkg::*;
    // single domain, so clock and reset are named once
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    AST_RST_ZERO: assert property ($fell(reset) |-> coeff_value == 24'h000000)
        else $error("coefficient not cleared by reset");
    AST_CAL_LOAD: assert property (cal_done |=> coeff_value == $past(cal_result))
        else $error("calibration result not loaded");
    AST_HOLD: assert property ($changed(coeff_value) |-> $past(cal_done) || acc_done)
        else $error("coefficient changed without cause");
    AST_DROP: assert property (wr_dropped |-> acc_done && ($stable(coeff_value) || $past(cal_done)))
        else $error("dropped write altered coefficient");
    AST_DONE: assert property (acc_done |-> $past(bit_stb) && !sdo)
        else $error("access end out of step with strobes");
    AST_LAT: assert property (raw_valid |-> ##3 res_valid)
        else $error("result not valid three cycles on");
    AST_BYP: assert property (raw_valid && self_gain_bypass && self_offset_bypass
        |-> ##3 res_data == $past(raw_result, 3)) else $error("bypass altered sample");
    AST_UNITY: assert property (raw_valid && self_offset_bypass && !self_gain_bypass
        ##1 coeff_value == 24'h400000 && !self_gain_bypass
        |-> ##2 res_data == $past(raw_result, 3)) else $error("unity gain altered sample");
endmodule
bind scg_top scg_props i_props (.mclk(mclk), .reset(reset), .bit_stb(bit_stb), .sdo(sdo),
    .acc_done(acc_done), .wr_dropped(wr_dropped), .cal_done(cal_done),
    .cal_result(cal_result), .self_gain_bypass(self_gain_bypass),
    .self_offset_bypass(self_offset_bypass), .raw_valid(raw_valid),
    .raw_result(raw_result), .res_valid(res_valid), .res_data(res_data),
    .coeff_value(coeff_value));

// File: tb/scg_host.sv
`timescale 1ns/1ps
// host side of the serial access, drives on falling edges
module scg_host (
    // clock
    input wire logic mclk,
    // access pins
    output logic acc_start,
    output logic acc_write,
    output logic bit_stb,
    output logic sdi,
    input wire logic sdo,
    input wire logic acc_done,
    input wire logic wr_dropped
);
    // idle pins at time zero
    initial begin
        acc_start = 1'b0;
        acc_write = 1'b0;
        bit_stb = 1'b0;
        sdi = 1'b0;
    end
    // one 24-bit access; gap idles between strobes like a slow host
    task automatic xfer(input logic wr, input logic [23:0] w, input int gap,
            output logic [23:0] rd, output logic done, output logic drop);
        @(negedge mclk);
        acc_start = 1'b1;
        acc_write = wr;
        for (int i = 23; i >= 0; i--) begin
            repeat (gap) begin
                @(negedge mclk);
                acc_start = 1'b0;
                bit_stb = 1'b0;
                sdi = ~sdi; // no stale bit left on an idle line
            end
            @(negedge mclk);
            acc_start = 1'b0;
            rd[i] = sdo;
            bit_stb = 1'b1;
            sdi = w[i];
        end
        @(negedge mclk);
        bit_stb = 1'b0;
        sdi = ~sdi;
        done = acc_done;
        drop = wr_dropped;
    endtask
endmodule

// File: tb/tb_self_cal_gain_register.sv
`timescale 1ns/1ps
module tb_self_cal_gain_register;
    import scg_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic acc_start, acc_write, bit_stb, sdi, sdo, acc_done, wr_dropped, res_valid;
    logic cal_busy = 1'b0;
    logic cal_done = 1'b0;
    logic self_gain_bypass = 1'b0;
    logic self_offset_bypass = 1'b0;
    logic raw_valid = 1'b0;
    scg_word_t cal_result = 24'h000000;
    scg_word_t self_cal_offset_coeff = 24'h000010;
    scg_word_t raw_result = 24'h000000;
    scg_word_t res_data, coeff_value;
    logic [23:0] rd;
    logic done, drop;
    int fails = 0;
    int checks_done = 0;
    // 40 ns period
    always #20 mclk = ~mclk;
    scg_top i_dut (.mclk(mclk), .reset(reset), .acc_start(acc_start),
        .acc_write(acc_write), .bit_stb(bit_stb), .sdi(sdi), .sdo(sdo),
        .acc_done(acc_done), .wr_dropped(wr_dropped), .cal_busy(cal_busy),
        .cal_done(cal_done), .cal_result(cal_result), .self_gain_bypass(self_gain_bypass),
        .self_offset_bypass(self_offset_bypass), .self_cal_offset_coeff(self_cal_offset_coeff),
        .raw_valid(raw_valid), .raw_result(raw_result), .res_valid(res_valid),
        .res_data(res_data), .coeff_value(coeff_value));
    scg_host i_host (.mclk(mclk), .acc_start(acc_start), .acc_write(acc_write),
        .bit_stb(bit_stb), .sdi(sdi), .sdo(sdo), .acc_done(acc_done), .wr_dropped(wr_dropped));
    // compare and count
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // write, then read back through the pins
    task automatic wr_rd(input logic [23:0] w, input int gap);
        i_host.xfer(1'b1, w, gap, rd, done, drop);
        chk("write status", 24'h2, {22'h0, done, drop});
        chk("coeff", w, coeff_value);
        i_host.xfer(1'b0, 24'h000000, gap, rd, done, drop);
        chk("readback", w, rd);
    endtask
    // load a coefficient, push one sample, check it three cycles on
    task automatic smp(input logic [23:0] c, r, input logic gb, ob, input logic [23:0] e);
        i_host.xfer(1'b1, c, 0, rd, done, drop);
        self_gain_bypass = gb;
        self_offset_bypass = ob;
        raw_result = r;
        raw_valid = 1'b1;
        @(negedge mclk);
        raw_valid = 1'b0;
        repeat (2) @(negedge mclk);
        chk("result", e, res_data);
        chk("result valid", 24'h1, {23'h0, res_valid});
    endtask
    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (20) @(negedge mclk);
        reset = 1'b0;
        chk("reset coeff", 24'h000000, coeff_value);
        wr_rd(24'ha5c3e1, 0);
        wr_rd(24'h800001, 2);
        $display("test access done");
        cal_busy = 1'b1;
        i_host.xfer(1'b1, 24'h123456, 0, rd, done, drop);
        chk("drop at start", 24'h3, {22'h0, done, drop});
        cal_result = 24'h5a5a5a;
        cal_done = 1'b1;
        @(negedge mclk);
        cal_done = 1'b0;
        cal_busy = 1'b0;
        chk("cal load", 24'h5a5a5a, coeff_value);
        // calibration starts halfway through a slow write
        fork
            i_host.xfer(1'b1, 24'h0f0f0f, 1, rd, done, drop);
            begin
                repeat (30) @(negedge mclk);
                cal_busy = 1'b1;
                @(negedge mclk);
                cal_busy = 1'b0;
            end
        join
        chk("drop mid write", 24'h3, {22'h0, done, drop});
        chk("coeff kept", 24'h5a5a5a, coeff_value);
        $display("test calibration done");
        smp(24'h600000, 24'h001010, 1'b0, 1'b0, 24'h001800);
        smp(24'h7fffff, 24'h001010, 1'b0, 1'b0, 24'h002000);
        smp(24'h600000, 24'hffeff0, 1'b0, 1'b0, 24'hffe7d0);
        smp(24'h400000, 24'h123456, 1'b0, 1'b1, 24'h123456);
        smp(24'h600000, 24'h001010, 1'b1, 1'b1, 24'h001010);
        smp(24'h600000, 24'h001010, 1'b1, 1'b0, 24'h001000);
        $display("test gain done");
        end_sim;
    end
    // watchdog, far beyond the few hundred cycles the tests take
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        end_sim;
    end
endmodule
